// File: hw/bsc_map_if.sv
// interface: set-point code to output voltage mapping request
`default_nettype none

interface bsc_map_if;
  logic [6:0]  code;
  logic [15:0] mv;
  logic        reserved;
  logic        unsupported;

  modport req (output code, input mv, input reserved, input unsupported);
  modport map (input code, output mv, output reserved, output unsupported);
endinterface : bsc_map_if

`default_nettype wire

// File: hw/bsc_pkg.sv
// package: register map, field layout and voltage coding for the buck set-point bank
// Notes on behaviour
// R1 - range bit 6 of run set-point register is read-only to the host
// R2 - range bit loads from default configuration, replaced only by one-time-programmed load
// R3 - range 0: code maps to 0.400 V plus 25 mV steps, 1.975 V at 63
// R4 - range 1: code maps to 0.800 V plus 50 mV steps, up to 3.300 V
// R5 - three independent 6-bit set points; the current mode's one is applied
// R6 - initial range bit copied into bit 6 of standby and sleep registers
// R7 - host must not program high-range codes 1110011 to 1111111, they are reserved
// R8 - host uses high range for 2.000-3.300 V, low range for 0.400-1.975 V
// R9 - host must not program set points of 0.6 V or below
// R10 - run, standby, sleep registers at 0x35, 0x36, 0x37; bit 7 unused
// R11 - host writes to the range bit are ignored, stored range unchanged
`default_nettype none

package bsc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RUN_SETPOINT_ADDR     = 8'h35;
  localparam logic [7:0] STANDBY_SETPOINT_ADDR = 8'h36;
  localparam logic [7:0] SLEEP_SETPOINT_ADDR   = 8'h37;

  localparam int         SETPOINT_W     = 6;
  localparam int         RANGE_BIT      = 6;
  localparam int         UNUSED_BIT     = 7;
  localparam logic [5:0] SETPOINT_RESET = 6'h00;
  localparam logic       RANGE_RESET    = 1'b0;

  // ----------------------------------------------------------------
  // voltage coding, millivolts
  // ----------------------------------------------------------------
  localparam logic [15:0] LOW_BASE_MV    = 16'h0190;  // 400
  localparam logic [15:0] LOW_STEP_MV    = 16'h0019;  // 25
  localparam logic [15:0] HIGH_BASE_MV   = 16'h0320;  // 800
  localparam logic [15:0] HIGH_STEP_MV   = 16'h0032;  // 50
  localparam logic [15:0] MIN_SUPPORT_MV = 16'h0258;  // 600, this and below unsupported
  localparam logic [5:0]  HIGH_LAST_CODE = 6'h32;     // 3.300 V

  // operating modes as seen on the mode pins
  typedef enum logic [1:0] {
    BSC_MODE_RUN     = 2'b00,
    BSC_MODE_STANDBY = 2'b01,
    BSC_MODE_SLEEP   = 2'b11
  } bsc_mode_e;

  function automatic logic [15:0] bsc_code_to_mv(input logic [6:0] code);
    logic [15:0] idx;
    idx = {10'h000, code[5:0]};
    if (code[RANGE_BIT]) begin
      bsc_code_to_mv = 16'(HIGH_BASE_MV + 16'(idx * HIGH_STEP_MV));
    end else begin
      bsc_code_to_mv = 16'(LOW_BASE_MV + 16'(idx * LOW_STEP_MV));
    end
  endfunction

endpackage : bsc_pkg

`default_nettype wire

// File: hw/bsc_top.sv
// module: set-point register bank and active set-point selection for the second buck regulator
`default_nettype none

module bsc_top
  import bsc_pkg::*;
#(
  parameter logic RANGE_DEFAULT = RANGE_RESET
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [1:0]  op_mode_pin,
  input  wire logic        otp_range_pin,
  input  wire logic        otp_load_pin,
  output logic      [6:0]  active_code,
  output logic      [15:0] target_mv,
  output logic             code_reserved,
  output logic             code_unsupported,
  output logic             range_high
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // a change counts only once stages two and three agree
  logic [1:0] mode_s1;
  logic [1:0] mode_s2;
  logic [1:0] mode_s3;
  logic [1:0] mode_q;
  logic [1:0] otp_s1;
  logic [1:0] otp_s2;
  logic [1:0] otp_s3;
  logic       otp_range_q;
  logic       otp_load_q;
  logic       otp_load_evt;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_s1 <= BSC_MODE_RUN;
      mode_s2 <= BSC_MODE_RUN;
      mode_s3 <= BSC_MODE_RUN;
      otp_s1  <= 2'h0;
      otp_s2  <= 2'h0;
      otp_s3  <= 2'h0;
    end else begin
      mode_s1 <= op_mode_pin;
      mode_s2 <= mode_s1;
      mode_s3 <= mode_s2;
      otp_s1  <= {otp_load_pin, otp_range_pin};
      otp_s2  <= otp_s1;
      otp_s3  <= otp_s2;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= BSC_MODE_RUN;
    end else if (mode_s2 == mode_s3) begin
      // code 2'b10 is not a mode; the last good one is kept
      if (mode_s3 != 2'b10) begin
        mode_q <= mode_s3;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      otp_range_q <= 1'b0;
      otp_load_q  <= 1'b0;
    end else begin
      if (otp_s2[0] == otp_s3[0]) begin
        otp_range_q <= otp_s3[0];
      end
      if (otp_s2[1] == otp_s3[1]) begin
        otp_load_q <= otp_s3[1];
      end
    end
  end

  // load acts once per settled rising edge of the load pin
  assign otp_load_evt = (otp_s2[1] && otp_s3[1]) && !otp_load_q;

  // ----------------------------------------------------------------
  // range bit
  // ----------------------------------------------------------------
  // one stored copy serves all three registers, so the modes cannot disagree
  logic range;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      range <= RANGE_DEFAULT;  // R2
    end else if (otp_load_evt) begin
      range <= otp_range_q;  // R2
    end
  end

  // ----------------------------------------------------------------
  // set-point registers
  // ----------------------------------------------------------------
  logic [5:0] run_sp;
  logic [5:0] stby_sp;
  logic [5:0] sleep_sp;

  // bit 6 and bit 7 of write data are dropped here
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_sp   <= SETPOINT_RESET;
      stby_sp  <= SETPOINT_RESET;
      sleep_sp <= SETPOINT_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        RUN_SETPOINT_ADDR:     run_sp   <= reg_wdata[5:0];  // R1 R11
        STANDBY_SETPOINT_ADDR: stby_sp  <= reg_wdata[5:0];  // R11
        SLEEP_SETPOINT_ADDR:   sleep_sp <= reg_wdata[5:0];  // R11
        default:               ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      RUN_SETPOINT_ADDR:     next_rdata = {1'b0, range, run_sp};  // R1 R10
      STANDBY_SETPOINT_ADDR: next_rdata = {1'b0, range, stby_sp};  // R6 R10
      SLEEP_SETPOINT_ADDR:   next_rdata = {1'b0, range, sleep_sp};  // R6 R10
      default:               next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // active set point
  // ----------------------------------------------------------------
  logic [5:0] next_sp;
  bsc_map_if  map_bus ();

  always_comb begin
    next_sp = run_sp;
    unique case (mode_q)
      BSC_MODE_RUN:     next_sp = run_sp;  // R5
      BSC_MODE_STANDBY: next_sp = stby_sp;  // R5
      BSC_MODE_SLEEP:   next_sp = sleep_sp;  // R5
      default:          next_sp = run_sp;
    endcase
  end

  assign map_bus.code = {range, next_sp};

  bsc_volt_map u_map (
    .m (map_bus.map)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_code      <= 7'h00;
      target_mv        <= LOW_BASE_MV;
      code_reserved    <= 1'b0;
      code_unsupported <= 1'b1;
      range_high       <= 1'b0;
    end else begin
      active_code      <= map_bus.code;
      target_mv        <= map_bus.mv;  // R3 R4
      code_reserved    <= map_bus.reserved;
      code_unsupported <= map_bus.unsupported;
      range_high       <= range;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_range_read_only: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
    (reg_wr && reg_addr == RUN_SETPOINT_ADDR && !otp_load_evt) |=> (range == $past(range)))
    else $error("range bit changed by a register write");

  a_otp_range_load: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
    otp_load_evt |=> (range == $past(otp_range_q)) ##1 (range_high == $past(range)))
    else $error("range bit not loaded from programmed value");

  a_low_range_map: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
    !active_code[RANGE_BIT] |-> (target_mv == 16'(LOW_BASE_MV + 16'({10'h000, active_code[5:0]} * LOW_STEP_MV))))
    else $error("low range voltage wrong");

  a_low_range_top: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
    (active_code == 7'h3f) |-> (target_mv == 16'h07b7))
    else $error("low range top code not 1975 mV");

  a_high_range_map: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
    (active_code == {1'b1, HIGH_LAST_CODE}) |-> (target_mv == 16'h0ce4) && !code_reserved)
    else $error("high range 3300 mV code wrong");

  a_mode_select: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
    (mode_q == BSC_MODE_SLEEP) |=> (active_code[5:0] == $past(sleep_sp)))
    else $error("sleep set point not applied");

  a_range_copied: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
    (reg_rd && reg_addr == STANDBY_SETPOINT_ADDR) |=> (reg_rdata[RANGE_BIT] == $past(range)))
    else $error("standby range bit differs from run range bit");

  a_sleep_map_read: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
    (reg_rd && reg_addr == SLEEP_SETPOINT_ADDR) |=> (reg_rdata == {1'b0, $past(range), $past(sleep_sp)}))
    else $error("sleep register read wrong");

  a_bit6_ignored: assert property (@(posedge core_clk) disable iff (!rst_n) // R11
    (reg_wr && reg_addr == STANDBY_SETPOINT_ADDR && !otp_load_evt)
      |=> (stby_sp == $past(reg_wdata[5:0])) && (range == $past(range)))
    else $error("standby write mishandled");

  a_below_floor: assert property (@(posedge core_clk) disable iff (!rst_n) // R9
    (active_code[6:0] == 7'h08) |-> code_unsupported)
    else $error("600 mV not flagged unsupported");

endmodule // bsc_top

`default_nettype wire

// File: hw/bsc_volt_map.sv
// module: decode of a 7-bit set-point code into millivolts and validity flags
`default_nettype none

module bsc_volt_map
  import bsc_pkg::*;
(
  bsc_map_if.map m
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    m.mv          = bsc_code_to_mv(m.code);  // R3 R4
    // high codes past 3.300 V have no defined output
    m.reserved    = m.code[RANGE_BIT] && (m.code[5:0] > HIGH_LAST_CODE);
    m.unsupported = (bsc_code_to_mv(m.code) <= MIN_SUPPORT_MV);
  end

endmodule // bsc_volt_map

`default_nettype wire

// File: verif/tb.sv
// testbench: self-checking random and corner-case run of the buck set-point register bank
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        core_clk;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [1:0]  op_mode_pin;
  logic        otp_range_pin;
  logic        otp_load_pin;
  logic [6:0]  active_code;
  logic [15:0] target_mv;
  logic        code_reserved;
  logic        code_unsupported;
  logic        range_high;
  int          n_errors = 0;
  int          n_tests  = 0;
  logic [5:0]  sp [3];
  logic [7:0]  rdv;
  logic [7:0]  t;
  logic [5:0]  c;
  logic        rng;

  bsc_top dut (
    .core_clk         (core_clk),
    .resetn           (resetn),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .op_mode_pin      (op_mode_pin),
    .otp_range_pin    (otp_range_pin),
    .otp_load_pin     (otp_load_pin),
    .active_code      (active_code),
    .target_mv        (target_mv),
    .code_reserved    (code_reserved),
    .code_unsupported (code_unsupported),
    .range_high       (range_high)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] exp_mv(input logic r, input logic [5:0] code);
    exp_mv = r ? 16'(800 + code * 50) : 16'(400 + code * 25);
  endfunction

  // random set points stay inside the host's legal window: high 2.000-3.300 V, low above 0.6 V
  function automatic logic [5:0] legal_code(input logic r, input logic [7:0] raw);
    legal_code = r ? 6'(24 + raw % 27) : 6'(9 + raw % 55);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    reg_wr    = 1'b0;
  endtask

  // read data lands on the edge after the strobe
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge core_clk);
    reg_rd   = 1'b0;
    rdv      = reg_rdata;
  endtask

  // mode pins need about five cycles to settle and reach the outputs
  task automatic check_mode(input logic [1:0] m, input int idx);
    logic [15:0] mv;
    op_mode_pin = m;
    repeat (8) @(negedge core_clk);
    mv = exp_mv(rng, sp[idx]);
    check({9'h000, active_code}, {9'h000, rng, sp[idx]});
    check(target_mv, mv);
    check({15'h0000, code_reserved}, {15'h0000, rng && (sp[idx] > 6'd50)});
    check({15'h0000, code_unsupported}, {15'h0000, mv <= 16'd600});
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn        = 1'b0;
    reg_addr      = 8'h00;
    reg_wdata     = 8'h00;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    op_mode_pin   = 2'b00;
    otp_range_pin = 1'b0;
    otp_load_pin  = 1'b0;
    rng           = 1'b0;
    sp            = '{6'h00, 6'h00, 6'h00};
    t             = 8'($urandom(32'he7851abe));
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    check({15'h0000, range_high}, 16'h0000);
    check(target_mv, 16'h0190);
    check({15'h0000, code_unsupported}, 16'h0001);
    for (int r = 0; r < 2; r++) begin
      rng = r[0];
      if (rng) begin
        // range pin settles well before the load edge
        otp_range_pin = 1'b1;
        repeat (4) @(negedge core_clk);
        otp_load_pin = 1'b1;
        repeat (6) @(negedge core_clk);
        otp_load_pin = 1'b0;
        check({15'h0000, range_high}, 16'h0001);
      end
      for (int i = 0; i < 3; i++) begin
        rd(8'(8'h35 + i));
        check({8'h00, rdv}, {8'h00, 1'b0, rng, sp[i]});
      end
      for (int k = 0; k < 6; k++) begin
        t = 8'($urandom);
        // corners 63 and 51 stray into reserved codes in the high range and 8 into an unsupported one in the low range, on purpose, to exercise the flags
        c = (k == 0) ? 6'd63 : (k == 1) ? 6'd50 : (k == 2) ? 6'd8 : (k == 3) ? 6'd51 : legal_code(rng, t);
        t = 8'($urandom);
        wr(8'h35, (k == 0) ? {1'b1, !rng, c} : {t[7:6], c});
        sp[0] = c;
        for (int i = 1; i < 3; i++) begin
          t = 8'($urandom);
          c = legal_code(rng, t);
          wr(8'(8'h35 + i), {t[7:6], c});
          sp[i] = c;
        end
        wr(8'h38, 8'hff);
        rd(8'h38);
        check({8'h00, rdv}, 16'h0000);
        for (int i = 0; i < 3; i++) begin
          rd(8'(8'h35 + i));
          check({8'h00, rdv}, {8'h00, 1'b0, rng, sp[i]});
        end
        check_mode(2'b00, 0);
        check_mode(2'b01, 1);
        check_mode(2'b11, 2);
        check_mode(2'b10, 2);
        op_mode_pin = 2'b00;
      end
    end
    wrap_up();
  end

  initial begin
    #(50 * 20000);
    n_errors++;
    wrap_up();
  end

endmodule // tb

`default_nettype wire
